// >>> include/bsp_pkg.sv
// Shared constants, types and selection decode for the stack pointer unit
package bsp_pkg;

  // Register numbering and widths
  localparam int ADDR_W = 32;
  localparam int SR_W = 16;
  localparam logic [2:0] SP_REG_IDX = 3'h7;

  // Operand size codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // Address step amounts in bytes
  localparam logic [2:0] STEP_BYTE = 3'h1;
  localparam logic [2:0] STEP_WORD = 3'h2;
  localparam logic [2:0] STEP_LONG = 3'h4;
  localparam logic [2:0] STEP_SP_BYTE = 3'h2;
  localparam logic [31:0] PC_STEP = 32'h4;
  localparam logic [31:0] SR_STEP = 32'h2;

  // Status word field positions
  localparam int SR_SUP_BIT = 13;
  localparam int SR_MASTER_BIT = 12;

  // Reset values
  localparam logic RST_SUP = 1'b1;
  localparam logic RST_MASTER = 1'b0;
  localparam logic [31:0] RST_ADDR = 32'h0;

  // Which physical stack pointer is live
  typedef enum logic [1:0] {SEL_USP, SEL_ISP, SEL_MSP} bsp_sel_t;

  // Request operations
  typedef enum logic [3:0] {
    OP_NONE, OP_READ, OP_WRITE, OP_PREDEC, OP_POSTINC,
    OP_CALL, OP_RETURN, OP_TRAP, OP_LOAD_SR
  } bsp_op_t;

  // Sequencer states
  typedef enum logic [0:0] {ST_IDLE, ST_TRAP_SR} bsp_state_t;

  // Pick the live stack pointer from the privilege flags
  function automatic bsp_sel_t sp_select(input logic sup, input logic master);
    if (!sup) begin
      return SEL_USP;
    end else if (master) begin
      return SEL_MSP;
    end
    return SEL_ISP;
  endfunction

endpackage

// >>> include/bsp_step_if.sv
// Carrier between the core and its step-size calculator
`timescale 1ns/100ps
interface bsp_step_if;
  logic [2:0] reg_idx;
  logic [1:0] size;
  logic [2:0] step;
  modport calc (input reg_idx, input size, output step);
  modport user (output reg_idx, output size, input step);
endinterface

// >>> src/bsp_step_calc.sv
// Address step size for predecrement and postincrement
`timescale 1ns/100ps
module bsp_step_calc
  import bsp_pkg::*;
(
  // Request and answer
  bsp_step_if.calc sif
);

  // Byte through the stack pointer keeps word alignment
  always_comb begin
    case (sif.size)
      SZ_BYTE: sif.step = (sif.reg_idx == SP_REG_IDX) ? STEP_SP_BYTE : STEP_BYTE; // see RL10
      SZ_WORD: sif.step = STEP_WORD; // see RL13
      default: sif.step = STEP_LONG; // see RL13
    endcase
  end

endmodule

// >>> src/bsp_core.sv
// Banked stack pointers, address registers and automatic address update
`timescale 1ns/100ps
// Functional notes
// [RL1] Register seven aliases the live stack pointer
// [RL2] Supervisor clear selects the user pointer
// [RL3] Supervisor and master set select master pointer
// [RL4] Supervisor set, master clear selects interrupt pointer
// [RL5] Reset leaves supervisor set, master clear
// [RL6] Supervisor pointer resolves to master when master set
// [RL7] Stacks grow down: push predecrements, pop postincrements
// [RL8] Call pushes program counter, return pops it
// [RL9] Trap saves counter and status on supervisor stack
// [RL10] Byte stack access through pointer steps two
// [RL11] Predecrement lowers register, then uses it
// [RL12] Postincrement uses register, then raises it
// [RL13] Other registers step by operand size
module bsp_core
  import bsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request port
  input wire logic req_valid,
  input wire logic [3:0] req_op,
  input wire logic [2:0] req_reg,
  input wire logic [1:0] req_size,
  input wire logic req_wr,
  input wire logic [31:0] req_data,
  input wire logic [31:0] req_pc,
  input wire logic [15:0] req_sr,
  // Memory access request
  output logic mem_valid,
  output logic mem_write,
  output logic [1:0] mem_size,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  // Register read answer and status
  output logic rd_valid,
  output logic [31:0] rd_data,
  output logic busy,
  output logic sup_flag,
  output logic master_flag,
  output logic [1:0] active_sel
);

  typedef struct packed {
    logic [6:0][31:0] areg;
    logic [31:0] unprivileged_stack_pointer;
    logic [31:0] privileged_exception_stack_pointer;
    logic [31:0] privileged_main_stack_pointer;
    logic sup;
    logic master;
    bsp_state_t state;
    logic [15:0] sr_hold;
    logic busy;
    logic mem_valid;
    logic mem_write;
    logic [1:0] mem_size;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic rd_valid;
    logic [31:0] rd_data;
    bsp_sel_t active_sel;
  } bsp_core_state_t;

  bsp_core_state_t state_reg;
  bsp_core_state_t state_next;
  bsp_step_if step_if ();
  bsp_sel_t cur_sel;
  bsp_sel_t sup_sel;
  logic [31:0] sp_now;
  logic [31:0] ssp_now;
  logic [31:0] reg_now;
  logic [31:0] step_ext;
  logic accept;
  bsp_op_t op;

  // Value of one physical stack pointer
  function automatic logic [31:0] sp_value(input bsp_core_state_t s, input bsp_sel_t sel);
    case (sel)
      SEL_USP: return s.unprivileged_stack_pointer;
      SEL_MSP: return s.privileged_main_stack_pointer;
      default: return s.privileged_exception_stack_pointer;
    endcase
  endfunction

  // Step size lookup
  bsp_step_calc u_step (
    .sif (step_if.calc)
  );

  // Operand decode
  assign op = bsp_op_t'(req_op);
  assign step_if.reg_idx = req_reg;
  assign step_if.size = req_size;
  assign step_ext = {29'h0, step_if.step};
  assign accept = req_valid && (state_reg.state == ST_IDLE);
  assign cur_sel = sp_select(state_reg.sup, state_reg.master); // see RL2, RL3, RL4
  assign sup_sel = sp_select(1'b1, state_reg.master); // see RL6, RL9
  assign sp_now = sp_value(state_reg, cur_sel);
  assign ssp_now = sp_value(state_reg, sup_sel);
  assign reg_now = (req_reg == SP_REG_IDX) ? sp_now : state_reg.areg[req_reg]; // see RL1

  // Next state
  always_comb begin
    logic wr_en;
    logic [2:0] wr_idx;
    bsp_sel_t wr_sel;
    logic [31:0] wr_val;
    logic [31:0] nv;
    wr_en = 1'b0;
    wr_idx = req_reg;
    wr_sel = cur_sel;
    wr_val = RST_ADDR;
    nv = RST_ADDR;
    state_next = state_reg;
    state_next.mem_valid = 1'b0;
    state_next.mem_write = 1'b0;
    state_next.rd_valid = 1'b0;
    case (state_reg.state)
      ST_IDLE: begin
        if (accept) begin
          case (op)
            OP_READ: begin
              state_next.rd_data = reg_now; // see RL1
              state_next.rd_valid = 1'b1;
            end
            OP_WRITE: begin
              wr_en = 1'b1; // see RL1
              wr_val = req_data;
            end
            OP_PREDEC: begin
              nv = reg_now - step_ext; // see RL11
              wr_en = 1'b1;
              wr_val = nv;
              state_next.mem_valid = 1'b1;
              state_next.mem_write = req_wr;
              state_next.mem_size = req_size;
              state_next.mem_addr = nv;
              state_next.mem_wdata = req_data;
            end
            OP_POSTINC: begin
              wr_en = 1'b1; // see RL12
              wr_val = reg_now + step_ext;
              state_next.mem_valid = 1'b1;
              state_next.mem_write = req_wr;
              state_next.mem_size = req_size;
              state_next.mem_addr = reg_now;
              state_next.mem_wdata = req_data;
            end
            OP_CALL: begin
              nv = sp_now - PC_STEP; // see RL7, RL8
              wr_en = 1'b1;
              wr_idx = SP_REG_IDX;
              wr_val = nv;
              state_next.mem_valid = 1'b1;
              state_next.mem_write = 1'b1;
              state_next.mem_size = SZ_LONG;
              state_next.mem_addr = nv;
              state_next.mem_wdata = req_pc;
            end
            OP_RETURN: begin
              wr_en = 1'b1; // see RL7, RL8
              wr_idx = SP_REG_IDX;
              wr_val = sp_now + PC_STEP;
              state_next.mem_valid = 1'b1;
              state_next.mem_size = SZ_LONG;
              state_next.mem_addr = sp_now;
            end
            OP_TRAP: begin
              nv = ssp_now - PC_STEP; // see RL9
              wr_en = 1'b1;
              wr_idx = SP_REG_IDX;
              wr_sel = sup_sel;
              wr_val = nv;
              state_next.sr_hold = req_sr;
              state_next.sr_hold[SR_SUP_BIT] = state_reg.sup;
              state_next.sr_hold[SR_MASTER_BIT] = state_reg.master;
              state_next.sup = 1'b1;
              state_next.mem_valid = 1'b1;
              state_next.mem_write = 1'b1;
              state_next.mem_size = SZ_LONG;
              state_next.mem_addr = nv;
              state_next.mem_wdata = req_pc;
              state_next.state = ST_TRAP_SR;
              state_next.busy = 1'b1;
            end
            OP_LOAD_SR: begin
              state_next.sup = req_sr[SR_SUP_BIT];
              state_next.master = req_sr[SR_MASTER_BIT];
            end
            default: begin
              state_next.busy = 1'b0;
            end
          endcase
        end
      end
      ST_TRAP_SR: begin
        nv = ssp_now - SR_STEP; // see RL9
        wr_en = 1'b1;
        wr_idx = SP_REG_IDX;
        wr_sel = sup_sel;
        wr_val = nv;
        state_next.mem_valid = 1'b1;
        state_next.mem_write = 1'b1;
        state_next.mem_size = SZ_WORD;
        state_next.mem_addr = nv;
        state_next.mem_wdata = {16'h0, state_reg.sr_hold};
        state_next.state = ST_IDLE;
        state_next.busy = 1'b0;
      end
      default: begin
        state_next.state = ST_IDLE;
        state_next.busy = 1'b0;
      end
    endcase
    // Register write through the alias
    if (wr_en) begin
      if (wr_idx == SP_REG_IDX) begin
        case (wr_sel) // see RL1
          SEL_USP: state_next.unprivileged_stack_pointer = wr_val;
          SEL_MSP: state_next.privileged_main_stack_pointer = wr_val;
          default: state_next.privileged_exception_stack_pointer = wr_val;
        endcase
      end else begin
        state_next.areg[wr_idx] = wr_val;
      end
    end
    state_next.active_sel = sp_select(state_next.sup, state_next.master);
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.sup <= RST_SUP; // see RL5
      state_reg.master <= RST_MASTER;
      state_reg.state <= ST_IDLE;
      state_reg.active_sel <= SEL_ISP;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign mem_valid = state_reg.mem_valid;
  assign mem_write = state_reg.mem_write;
  assign mem_size = state_reg.mem_size;
  assign mem_addr = state_reg.mem_addr;
  assign mem_wdata = state_reg.mem_wdata;
  assign rd_valid = state_reg.rd_valid;
  assign rd_data = state_reg.rd_data;
  assign busy = state_reg.busy;
  assign sup_flag = state_reg.sup;
  assign master_flag = state_reg.master;
  assign active_sel = state_reg.active_sel;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_trap_req;
    accept && op == OP_TRAP;
  endsequence

  sequence seq_trap_frame;
    mem_write && mem_size == SZ_LONG ##1
      mem_write && mem_size == SZ_WORD && mem_addr == $past(mem_addr) - SR_STEP;
  endsequence

  chk_user_sel: assert property (!sup_flag |-> active_sel == SEL_USP) // see RL2
    else $error("user mode not on user pointer");
  chk_master_sel: assert property (sup_flag && master_flag |-> active_sel == SEL_MSP) // see RL3
    else $error("master pointer not selected");
  chk_intr_sel: assert property (sup_flag && !master_flag |-> active_sel == SEL_ISP) // see RL4
    else $error("interrupt pointer not selected");
  chk_reset_flags: assert property ($rose(rst_n) |-> sup_flag && !master_flag) // see RL5
    else $error("flags wrong after reset");
  chk_alias_write: assert property ( // see RL1, RL6
    accept && op == OP_WRITE && req_reg == SP_REG_IDX |=> sp_now == $past(req_data))
    else $error("alias write missed live pointer");
  chk_call_push: assert property ( // see RL7, RL8
    accept && op == OP_CALL |=> mem_write && mem_addr == $past(sp_now) - PC_STEP
      && mem_wdata == $past(req_pc) && sp_now == mem_addr)
    else $error("call push wrong");
  chk_return_pop: assert property ( // see RL8
    accept && op == OP_RETURN |=> !mem_write && mem_addr == $past(sp_now)
      && sp_now == mem_addr + PC_STEP)
    else $error("return pop wrong");
  chk_trap_frame: assert property ( // see RL9
    seq_trap_req |=> seq_trap_frame ##0 sup_flag && active_sel != SEL_USP)
    else $error("trap frame wrong");
  chk_trap_user_kept: assert property ( // see RL9
    seq_trap_req |=> state_reg.unprivileged_stack_pointer == $past(state_reg.unprivileged_stack_pointer) [*2])
    else $error("trap touched user pointer");
  chk_sp_byte_step: assert property ( // see RL10, RL11
    accept && op == OP_PREDEC && req_reg == SP_REG_IDX && req_size == SZ_BYTE
      |=> mem_addr == $past(sp_now) - SR_STEP)
    else $error("byte stack step not two");
  chk_predec_long: assert property ( // see RL11, RL13
    accept && op == OP_PREDEC && req_reg != SP_REG_IDX && req_size == SZ_LONG
      |=> mem_addr == $past(reg_now) - PC_STEP)
    else $error("predecrement address wrong");
  chk_postinc_byte: assert property ( // see RL12, RL13
    accept && op == OP_POSTINC && req_reg != SP_REG_IDX && req_size == SZ_BYTE
      |=> mem_addr == $past(reg_now) && state_reg.areg[$past(req_reg)] == mem_addr + 32'h1)
    else $error("postincrement wrong");

endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the banked stack pointer unit
`timescale 1ns/100ps
module tb_top;
  import bsp_pkg::*;
  logic clk, rst_n, req_valid, req_wr;
  logic [3:0] req_op;
  logic [2:0] req_reg;
  logic [1:0] req_size;
  logic [31:0] req_data, req_pc;
  logic [15:0] req_sr;
  logic mem_valid, mem_write, rd_valid, busy, sup_flag, master_flag;
  logic [1:0] mem_size, active_sel;
  logic [31:0] mem_addr, mem_wdata, rd_data;
  int errors, n_compared;
  // Status words for user, interrupt and master modes
  localparam logic [15:0] MODE_SR [3] = '{16'h0000, 16'h2000, 16'h3000};

  bsp_core u_bsp_core (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
    .req_reg(req_reg), .req_size(req_size), .req_wr(req_wr), .req_data(req_data),
    .req_pc(req_pc), .req_sr(req_sr), .mem_valid(mem_valid), .mem_write(mem_write),
    .mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .rd_valid(rd_valid),
    .rd_data(rd_data), .busy(busy), .sup_flag(sup_flag), .master_flag(master_flag),
    .active_sel(active_sel));

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One request, held over its accept edge; returns just after it
  task automatic issue(input bsp_op_t op, input logic [2:0] r, input logic [1:0] sz,
                       input logic [31:0] d, input logic [15:0] sr);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_op = op;
    req_reg = r;
    req_size = sz;
    req_wr = (op == OP_PREDEC);
    req_data = d;
    req_pc = d;
    req_sr = sr;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
  endtask

  task automatic set_mode(input int i);
    issue(OP_LOAD_SR, 3'h0, SZ_LONG, 32'h0, MODE_SR[i]);
  endtask

  task automatic rd_reg(input logic [2:0] r, input logic [31:0] exp);
    issue(OP_READ, r, SZ_LONG, 32'h0, 16'h0);
    chk({31'h0, rd_valid}, 32'h1);
    chk(rd_data, exp);
  endtask

  task automatic t_reset();
    chk({30'h0, active_sel}, 32'h1);
    chk({30'h0, sup_flag, master_flag}, 32'h2);
    $display("test reset done");
  endtask

  task automatic t_select();
    for (int i = 0; i < 3; i++) begin
      set_mode(i);
      chk({30'h0, active_sel}, 32'(i));
    end
    $display("test select done");
  endtask

  task automatic t_alias();
    for (int i = 0; i < 3; i++) begin
      set_mode(i);
      issue(OP_WRITE, SP_REG_IDX, SZ_LONG, 32'h1000 + 32'(i) * 32'h100, 16'h0);
    end
    for (int i = 0; i < 3; i++) begin
      set_mode(i);
      rd_reg(SP_REG_IDX, 32'h1000 + 32'(i) * 32'h100);
    end
    $display("test alias done");
  endtask

  task automatic t_call();
    set_mode(2);
    issue(OP_CALL, 3'h0, SZ_LONG, 32'habc, 16'h0);
    chk({mem_valid, mem_write, mem_size}, {2'b11, SZ_LONG});
    chk(mem_addr, 32'h11fc);
    chk(mem_wdata, 32'habc);
    issue(OP_RETURN, 3'h0, SZ_LONG, 32'h0, 16'h0);
    chk({mem_valid, mem_write}, 2'b10);
    chk(mem_addr, 32'h11fc);
    rd_reg(SP_REG_IDX, 32'h1200);
    $display("test call done");
  endtask

  task automatic t_trap();
    set_mode(0);
    issue(OP_TRAP, 3'h0, SZ_LONG, 32'h55, 16'h00ff);
    chk({mem_valid, mem_write, busy, sup_flag}, 4'hf);
    chk(mem_addr, 32'h10fc);
    chk(mem_wdata, 32'h55);
    @(posedge clk);
    #1;
    chk({mem_valid, mem_write, busy, mem_size}, {3'b110, SZ_WORD});
    chk(mem_addr, 32'h10fa);
    chk({16'h0, mem_wdata[15:0]}, 32'h00ff);
    chk({30'h0, active_sel}, 32'h1);
    rd_reg(SP_REG_IDX, 32'h10fa);
    set_mode(0);
    rd_reg(SP_REG_IDX, 32'h1000);
    $display("test trap done");
  endtask

  task automatic t_step();
    logic [31:0] st;
    set_mode(1);
    issue(OP_WRITE, 3'h3, SZ_LONG, 32'h100, 16'h0);
    for (int k = 0; k < 3; k++) begin
      st = (k == 0) ? 32'h1 : (k == 1) ? 32'h2 : 32'h4;
      issue(OP_PREDEC, 3'h3, 2'(k), 32'h77, 16'h0);
      chk({mem_valid, mem_write}, 2'b11);
      chk(mem_addr, 32'h100 - st);
      issue(OP_POSTINC, 3'h3, 2'(k), 32'h0, 16'h0);
      chk(mem_addr, 32'h100 - st);
      rd_reg(3'h3, 32'h100);
    end
    issue(OP_WRITE, SP_REG_IDX, SZ_LONG, 32'h200, 16'h0);
    issue(OP_PREDEC, SP_REG_IDX, SZ_BYTE, 32'h0, 16'h0);
    chk(mem_addr, 32'h1fe);
    issue(OP_POSTINC, SP_REG_IDX, SZ_BYTE, 32'h0, 16'h0);
    chk(mem_addr, 32'h1fe);
    rd_reg(SP_REG_IDX, 32'h200);
    $display("test step done");
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog far beyond the expected hundred or so cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = 4'h0;
    req_reg = 3'h0;
    req_size = 2'h0;
    req_wr = 1'b0;
    req_data = 32'h0;
    req_pc = 32'h0;
    req_sr = 16'h0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_select();
    t_alias();
    t_call();
    t_trap();
    t_step();
    print_verdict();
  end
endmodule
